// ==== timer_mode_ctl.sv ====
`timescale 1ns/1ps
`include "timer_mode_regs.svh"
module timer_mode_ctl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hw_standby,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Counter events, index order ch0 A B C D, ch1 A B, ch2 A B
  input  wire logic [7:0]  cmp_match,
  input  wire logic [2:0]  cnt_clear,
  input  wire logic        chan1_count_pulse,
  // Pins
  input  wire logic [7:0]  cap_pin,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_n,
  output logic      [7:0]  capture,
  // Mode outputs for the counters
  output timer_mode_pkg::op_mode_type ch0_mode,
  output timer_mode_pkg::op_mode_type ch1_mode,
  output timer_mode_pkg::op_mode_type ch2_mode,
  output logic             buffer_a_enable,
  output logic             buffer_b_enable,
  output logic      [2:0]  counter_start_bit,
  output logic      [2:0]  prescaler_select
);

  logic       rst_meta_reg;
  logic       rst_n;
  logic [8:0] sync_out;
  logic [7:0] pin_sync;
  logic       standby_s;
  logic [7:0] ch0_mode_reg;
  logic [7:0] ch1_mode_reg;
  logic [7:0] ch2_mode_reg;
  logic [7:0] ch0_pin_high_reg;
  logic [7:0] ch0_pin_low_reg;
  logic [7:0] ch1_pin_reg;
  logic [7:0] ch2_pin_reg;
  logic [2:0] start_reg;
  logic [2:0] presc_reg;
  logic       wr_en;
  logic       setup;
  logic [7:0] read_next;
  logic [3:0] func_sel [8];
  logic [7:0] active_sel;
  logic       count_source;

  function automatic timer_mode_pkg::op_mode_type decode_mode(
    input logic [3:0] f
  );
    case (f)
      4'h2:    decode_mode = timer_mode_pkg::MODE_PWM1;
      4'h3:    decode_mode = timer_mode_pkg::MODE_PWM2;
      4'h4:    decode_mode = timer_mode_pkg::MODE_PHASE1;
      4'h5:    decode_mode = timer_mode_pkg::MODE_PHASE2;
      4'h6:    decode_mode = timer_mode_pkg::MODE_PHASE3;
      4'h7:    decode_mode = timer_mode_pkg::MODE_PHASE4;
      default: decode_mode = timer_mode_pkg::MODE_NORMAL;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `CH0_MODE_OFF, `CH1_MODE_OFF, `CH2_MODE_OFF,
      `CH0_PIN_HIGH_OFF, `CH0_PIN_LOW_OFF, `CH1_PIN_OFF,
      `CH2_PIN_OFF, `START_OFF, `PRESC1_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] chan_of(input int idx);
    chan_of = (idx < 4) ? 2'h0 : ((idx < 6) ? 2'h1 : 2'h2);
  endfunction

  // Asynchronous assert, synchronous release
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  sync_two #(
    .WIDTH (9)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({hw_standby, cap_pin}),
    .dout  (sync_out)
  );

  assign pin_sync  = sync_out[7:0];
  assign standby_s = sync_out[8];

  // Zero wait states; read data latched in the setup cycle
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  always_comb
  begin
    read_next = 8'h00;
    case (paddr)
      `CH0_MODE_OFF:     read_next = ch0_mode_reg;
      `CH1_MODE_OFF:     read_next = ch1_mode_reg;
      `CH2_MODE_OFF:     read_next = ch2_mode_reg;
      `CH0_PIN_HIGH_OFF: read_next = ch0_pin_high_reg;
      `CH0_PIN_LOW_OFF:  read_next = ch0_pin_low_reg;
      `CH1_PIN_OFF:      read_next = ch1_pin_reg;
      `CH2_PIN_OFF:      read_next = ch2_pin_reg;
      `START_OFF:        read_next = {5'h00, start_reg};
      `PRESC1_OFF:       read_next = {5'h00, presc_reg};
      default:           read_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= {24'h00_0000, read_next};
  end

  // Mode registers; fixed bits are rebuilt on every write
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch0_mode_reg <= `MODE_RESET;
      ch1_mode_reg <= `MODE_RESET;
      ch2_mode_reg <= `MODE_RESET;
    end
    else if (standby_s)
    begin
      ch0_mode_reg <= `MODE_RESET;
      ch1_mode_reg <= `MODE_RESET;
      ch2_mode_reg <= `MODE_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        `CH0_MODE_OFF:
          ch0_mode_reg <= {`MODE_FIXED_ONES, pwdata[5:0]};
        `CH1_MODE_OFF:
          ch1_mode_reg <= {`MODE_FIXED_ONES, 2'h0, pwdata[3:0]};
        `CH2_MODE_OFF:
          ch2_mode_reg <= {`MODE_FIXED_ONES, 2'h0, pwdata[3:0]};
        default:
          ch0_mode_reg <= ch0_mode_reg;
      endcase
    end
  end

  // Pin control registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch0_pin_high_reg <= `PIN_CTL_RESET;
      ch0_pin_low_reg  <= `PIN_CTL_RESET;
      ch1_pin_reg      <= `PIN_CTL_RESET;
      ch2_pin_reg      <= `PIN_CTL_RESET;
    end
    else if (standby_s)
    begin
      ch0_pin_high_reg <= `PIN_CTL_RESET;
      ch0_pin_low_reg  <= `PIN_CTL_RESET;
      ch1_pin_reg      <= `PIN_CTL_RESET;
      ch2_pin_reg      <= `PIN_CTL_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        `CH0_PIN_HIGH_OFF: ch0_pin_high_reg <= pwdata[7:0];
        `CH0_PIN_LOW_OFF:  ch0_pin_low_reg  <= pwdata[7:0];
        `CH1_PIN_OFF:      ch1_pin_reg      <= pwdata[7:0];
        `CH2_PIN_OFF:      ch2_pin_reg      <= pwdata[7:0];
        default:           ch1_pin_reg      <= ch1_pin_reg;
      endcase
    end
  end

  // Start bits and channel 1 prescaler select
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_reg <= `START_RESET;
      presc_reg <= `PRESC_RESET;
    end
    else if (standby_s)
    begin
      start_reg <= `START_RESET;
      presc_reg <= `PRESC_RESET;
    end
    else if (wr_en && paddr == `START_OFF)
      start_reg <= pwdata[2:0];
    else if (wr_en && paddr == `PRESC1_OFF)
      presc_reg <= pwdata[2:0];
  end

  // Phase modes on channels 0 and 2 are stored as written and decoded
  // as given; software is expected to keep them out.
  assign ch0_mode          = decode_mode(ch0_mode_reg[3:0]);
  assign ch1_mode          = decode_mode(ch1_mode_reg[3:0]);
  assign ch2_mode          = decode_mode(ch2_mode_reg[3:0]);
  assign buffer_a_enable   = ch0_mode_reg[`BUF_A_BIT];
  assign buffer_b_enable   = ch0_mode_reg[`BUF_B_BIT];
  assign counter_start_bit = start_reg;
  assign prescaler_select  = presc_reg;

  // Field routing: high nibble B or D, low nibble A or C
  always_comb
  begin
    func_sel[0] = ch0_pin_high_reg[3:0];
    func_sel[1] = ch0_pin_high_reg[7:4];
    func_sel[2] = ch0_pin_low_reg[3:0];
    func_sel[3] = ch0_pin_low_reg[7:4];
    func_sel[4] = ch1_pin_reg[3:0];
    func_sel[5] = ch1_pin_reg[7:4];
    func_sel[6] = ch2_pin_reg[3:0];
    func_sel[7] = ch2_pin_reg[7:4];
  end

  // A buffering C or D drives nothing and captures nothing
  assign active_sel = {4'hF, ~buffer_b_enable,
                       ~buffer_a_enable, 2'h3};

  // Field of a buffering register is masked, not ignored: it still sets the pin level
  logic [7:0] active_fin;
  assign active_fin = active_sel;

  // Undivided channel 1 clock gives no count capture
  assign count_source = chan1_count_pulse &&
                        (presc_reg != `PRESC_UNDIVIDED);

  timer_mode_pkg::op_mode_type mode_of [3];
  assign mode_of[0] = ch0_mode;
  assign mode_of[1] = ch1_mode;
  assign mode_of[2] = ch2_mode;

  for (genvar g = 0; g < 8; g++)
  begin : gen_pin
    pin_ctl_if pc ();

    assign pc.func      = func_sel[g];
    assign pc.active    = active_fin[g];
    assign pc.running   = start_reg[chan_of(g)];
    assign pc.pwm2      = mode_of[chan_of(g)] ==
                          timer_mode_pkg::MODE_PWM2;
    assign pc.match     = cmp_match[g];
    assign pc.clear     = cnt_clear[chan_of(g)];
    assign pc.cnt_event = count_source;
    assign pc.pin_in    = pin_sync[g];
    assign pin_out[g]   = pc.pin_out;
    assign pin_oe_n[g]  = pc.pin_oe_n;
    assign capture[g]   = pc.capture;

    // Capture codes are only defined for channel 0
    pin_unit #(
      .ALLOW_CAPTURE (g < 4)
    ) u_pin (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pc    (pc.unit)
    );
  end

  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence standby_held;
    standby_s [*2];
  endsequence

  a_mode_standby: assert property (
      standby_held |-> ch0_mode_reg == 8'hC0
      && ch1_mode_reg == 8'hC0 && ch2_mode_reg == 8'hC0)
    else $error("mode register not at C0 in standby");
  a_mode_ones: assert property (
      ch0_mode_reg[7:6] == 2'h3
      && ch1_mode_reg[7:6] == 2'h3 && ch2_mode_reg[7:6] == 2'h3)
    else $error("mode top bits not one");
  a_reserved_zero: assert property (
      ch1_mode_reg[5:4] == 2'h0 && ch2_mode_reg[5:4] == 2'h0)
    else $error("channel 1 or 2 buffer bits not zero");
  a_buffer_d_quiet: assert property (
      buffer_b_enable [*2] |-> pin_oe_n[3] && !capture[3])
    else $error("buffered register D still active");
  a_buffer_c_quiet: assert property (
      buffer_a_enable [*2] |-> pin_oe_n[2] && !capture[2])
    else $error("buffered register C still active");
  a_pin_standby: assert property (
      standby_held |-> ch0_pin_high_reg == 8'h00 && ch0_pin_low_reg == 8'h00
      && ch1_pin_reg == 8'h00 && ch2_pin_reg == 8'h00)
    else $error("pin control not cleared in standby");
  // Count source gated in the same cycle the prescaler reads 000
  a_count_blocked: assert property (
      presc_reg == `PRESC_UNDIVIDED && func_sel[1][3:2] == 2'h3
      |=> !capture[1])
    else $error("count capture with undivided clock");
  // Channel 2 A is the register that runs PWM mode 2 in use
  a_pwm2_clear: assert property (
      start_reg[2] && ch2_mode_reg[3:0] == 4'h3 && cnt_clear[2]
      |=> pin_out[6] == $past(ch2_pin_reg[2]))
    else $error("pwm2 clear level wrong");
endmodule

// ==== timer_mode_regs.svh ====
`ifndef TIMER_MODE_REGS_SVH
`define TIMER_MODE_REGS_SVH

// Register byte offsets
`define CH0_MODE_OFF      8'h00
`define CH1_MODE_OFF      8'h04
`define CH2_MODE_OFF      8'h08
`define CH0_PIN_HIGH_OFF  8'h0C
`define CH0_PIN_LOW_OFF   8'h10
`define CH1_PIN_OFF       8'h14
`define CH2_PIN_OFF       8'h18
`define START_OFF         8'h1C
`define PRESC1_OFF        8'h20

// Reset values
`define MODE_RESET        8'hC0
`define PIN_CTL_RESET     8'h00
`define START_RESET       3'h0
`define PRESC_RESET       3'h0

// Field positions and codes
`define MODE_FIXED_ONES   2'h3
`define BUF_B_BIT         5
`define BUF_A_BIT         4
`define PRESC_UNDIVIDED   3'h0

`endif

// ==== timer_mode_pkg.sv ====
package timer_mode_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_PWM1,
    MODE_PWM2,
    MODE_PHASE1,
    MODE_PHASE2,
    MODE_PHASE3,
    MODE_PHASE4
  } op_mode_type;

endpackage

// ==== pin_ctl_if.sv ====
`timescale 1ns/1ps
interface pin_ctl_if;
  logic [3:0] func;
  logic       active;
  logic       running;
  logic       pwm2;
  logic       match;
  logic       clear;
  logic       cnt_event;
  logic       pin_in;
  logic       pin_out;
  logic       pin_oe_n;
  logic       capture;

  modport ctl (output func, active, running, pwm2, match, clear,
               cnt_event, pin_in, input pin_out, pin_oe_n, capture);
  modport unit (input func, active, running, pwm2, match, clear,
                cnt_event, pin_in, output pin_out, pin_oe_n, capture);
endinterface

// ==== sync_two.sv ====
`timescale 1ns/1ps
module sync_two #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] first_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_reg <= '0;
      dout      <= '0;
    end
    else
    begin
      first_reg <= din;
      dout      <= first_reg;
    end
  end
endmodule

// ==== pin_unit.sv ====
`timescale 1ns/1ps
module pin_unit #(
  parameter bit ALLOW_CAPTURE = 1'b1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control and pin
  pin_ctl_if.unit   pc
);
  logic out_en;
  logic pin_prev_reg;
  logic cap_next;

  assign out_en = pc.active && !pc.func[3] && (pc.func[1:0] != 2'h0);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pc.pin_oe_n <= 1'b1;
    else
      pc.pin_oe_n <= !out_en;
  end

  // Level tracks the initial code until the counter runs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pc.pin_out <= 1'b0;
    else if (!pc.running)
      pc.pin_out <= pc.func[2];
    else if (pc.pwm2 && pc.clear)
      pc.pin_out <= pc.func[2];
    else if (out_en && pc.match)
    begin
      case (pc.func[1:0])
        2'h1:    pc.pin_out <= 1'b0;
        2'h2:    pc.pin_out <= 1'b1;
        2'h3:    pc.pin_out <= !pc.pin_out;
        default: pc.pin_out <= pc.pin_out;
      endcase
    end
  end

  always_comb
  begin
    cap_next = 1'b0;
    if (ALLOW_CAPTURE && pc.active && pc.func[3])
    begin
      if (pc.func[2])
        cap_next = pc.cnt_event;
      else if (pc.func[1])
        cap_next = pc.pin_in != pin_prev_reg;
      else if (pc.func[0])
        cap_next = pin_prev_reg && !pc.pin_in;
      else
        cap_next = !pin_prev_reg && pc.pin_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_prev_reg <= 1'b0;
      pc.capture   <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= pc.pin_in;
      pc.capture   <= cap_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_output_disable: assert property (
      (pc.func[1:0] == 2'h0) |=> pc.pin_oe_n)
    else $error("output enabled for a disable code");
  a_initial_level: assert property (
      !pc.running |=> pc.pin_out == $past(pc.func[2]))
    else $error("stopped pin not at initial level");
  a_toggle_match: assert property (
      pc.running && !(pc.pwm2 && pc.clear) && out_en
      && pc.match && pc.func[1:0] == 2'h3
      |=> pc.pin_out != $past(pc.pin_out))
    else $error("toggle at match missing");
  a_rise_capture: assert property (
      ALLOW_CAPTURE && pc.active && pc.func == 4'h8
      && !pin_prev_reg && pc.pin_in |=> pc.capture)
    else $error("rising edge capture missing");
endmodule

// ==== pin_partner.sv ====
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input  wire logic       mclk,
  // Design pin side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] capture,
  // Wire level seen by the capture inputs
  output logic      [7:0] cap_pin
);
  logic [7:0] ext;
  int         cap_cnt [8];

  // A driven pin shows the design's level, otherwise the outside level
  assign cap_pin = (pin_oe_n & ext) | (~pin_oe_n & pin_out);

  initial ext = 8'h00;

  always @(posedge mclk)
    for (int i = 0; i < 8; i++)
      if (capture[i] === 1'b1)
        cap_cnt[i]++;

  task automatic clr();
    for (int i = 0; i < 8; i++)
      cap_cnt[i] = 0;
  endtask

  // Slow edges, well apart for the two-flop sampling
  task automatic wiggle(input int idx, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      ext[idx] <= ~ext[idx];
      repeat (5) @(posedge mclk);
    end
  endtask
endmodule

// ==== tb_timer_mode_and_io_control.sv ====
`timescale 1ns/1ps
`include "timer_mode_regs.svh"
module tb_timer_mode_and_io_control;
  logic        mclk, nrst, hw_standby, psel, penable, pwrite;
  logic [7:0]  paddr, cmp_match, cap_pin, pin_out, pin_oe_n, capture, q, m;
  logic [1:0]  x;
  logic [31:0] pwdata, prdata, lfsr;
  logic        pready, pslverr, chan1_count_pulse, e;
  logic        buffer_a_enable, buffer_b_enable;
  logic [2:0]  cnt_clear, counter_start_bit, prescaler_select;
  timer_mode_pkg::op_mode_type ch0_mode, ch1_mode, ch2_mode;
  int          err_total, total_checks, mdl [9], c, a;
  int          ccode [4] = '{8, 9, 10, 12};
  int          ccnt [4] = '{1, 1, 2, 3};

  timer_mode_ctl dut (.mclk, .nrst, .hw_standby, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_match, .cnt_clear,
    .chan1_count_pulse, .cap_pin, .pin_out, .pin_oe_n, .capture, .ch0_mode,
    .ch1_mode, .ch2_mode, .buffer_a_enable, .buffer_b_enable,
    .counter_start_bit, .prescaler_select);

  pin_partner partner (.mclk, .pin_out, .pin_oe_n, .capture, .cap_pin);

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      conclude();
    end
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] ad, d);
    apb(1'b1, ad, d);
    case (ad)
      `CH0_MODE_OFF: mdl[0] = 8'hC0 | (d & 8'h3F);
      `CH1_MODE_OFF, `CH2_MODE_OFF:
        mdl[ad >> 2] = 8'hC0 | (d & 8'h0F);
      `START_OFF, `PRESC1_OFF: mdl[ad >> 2] = d & 8'h07;
      default: mdl[ad >> 2] = d;
    endcase
  endtask

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 8'h00);
    chk("register", {24'h0, q}, mdl[ad >> 2]);
  endtask

  task automatic mdl_reset();
    for (int i = 0; i < 9; i++)
      mdl[i] = (i < 3) ? 8'hC0 : 8'h00;
  endtask

  task automatic pulse_count(input int n);
    repeat (n)
    begin
      chan1_count_pulse <= 1'b1;
      @(posedge mclk);
      chan1_count_pulse <= 1'b0;
      @(posedge mclk);
    end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] xmode(input int m);
    if (m < 2)
      return 32'(timer_mode_pkg::MODE_NORMAL);
    return 32'(int'(timer_mode_pkg::MODE_PWM1) + m - 2);
  endfunction

  initial
  begin
    #2500000;
    err_total++;
    conclude();
  end

  initial
  begin
    {nrst, hw_standby, psel, penable, pwrite, chan1_count_pulse} = '0;
    {paddr, pwdata, cmp_match, cnt_clear} = '0;
    lfsr = 32'hBDEF9F48;
    mdl_reset();
    tick(4);
    nrst <= 1'b1;
    tick(3);
    for (int i = 0; i < 9; i++)
      rd(8'(4 * i));
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    // Phase codes only on channel 1, top mode bit kept zero
    repeat (10)
      for (int i = 0; i < 7; i++)
      begin
        lfsr = nxt(lfsr);
        m = (i == 1) ? 8'h77 : ((i < 3) ? 8'h33 : 8'hFF);
        wr(8'(4 * i), lfsr[7:0] & m);
        rd(8'(4 * i));
      end
    for (int i = 0; i < 9; i++)
      wr(8'(4 * i), 8'h00);
    for (c = 0; c < 8; c++)
    begin
      wr(`CH1_MODE_OFF, 8'(c));
      chk("ch1 mode", 32'(ch1_mode), xmode(c));
      wr(`CH0_MODE_OFF, 8'(8'h30 | (c & 3)));
      chk("ch0 mode", 32'(ch0_mode), xmode(c & 3));
      chk("buffers", {buffer_b_enable, buffer_a_enable}, 3);
      wr(`CH2_MODE_OFF, 8'(c & 3));
      chk("ch2 mode", 32'(ch2_mode), xmode(c & 3));
    end
    wr(`CH1_MODE_OFF, 8'h00);
    wr(`CH0_MODE_OFF, 8'h00);
    wr(`CH2_MODE_OFF, 8'h00);
    // Same code in both nibbles, match on A only
    for (c = 0; c < 8; c++)
    begin
      a = c & 3;
      x = {c[2], (a == 3) ? !c[2] : a[1]};
      wr(`CH1_PIN_OFF, 8'(c * 17));
      tick(2);
      chk("oe", pin_oe_n[5:4], (a == 0) ? 2'b11 : 2'b00);
      if (a != 0)
        chk("init", pin_out[5:4], {2{c[2]}});
      wr(`START_OFF, 8'h02);
      chk("start out", counter_start_bit, 3'h2);
      cmp_match <= 8'h10;
      @(posedge mclk);
      cmp_match <= 8'h00;
      tick(2);
      if (a != 0)
        chk("match", pin_out[5:4], x);
      wr(`START_OFF, 8'h00);
      tick(2);
      if (a != 0)
        chk("stop", pin_out[5:4], {2{c[2]}});
    end
    wr(`CH2_MODE_OFF, 8'h03);
    wr(`CH2_PIN_OFF, 8'h05);
    wr(`START_OFF, 8'h04);
    chk("start out", counter_start_bit, 3'h4);
    cmp_match <= 8'h40;
    @(posedge mclk);
    cmp_match <= 8'h00;
    tick(2);
    chk("pwm2 match", pin_out[6], 0);
    cnt_clear <= 3'b100;
    @(posedge mclk);
    cnt_clear <= 3'b000;
    tick(2);
    chk("pwm2 clear", pin_out[6], 1);
    wr(`START_OFF, 8'h00);
    wr(`PRESC1_OFF, 8'h01);
    chk("presc out", prescaler_select, 3'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(`CH0_PIN_HIGH_OFF, 8'(ccode[i] << 4));
      partner.clr();
      partner.wiggle(1, 2);
      pulse_count(3);
      tick(4);
      chk("capture", partner.cap_cnt[1], ccnt[i]);
    end
    wr(`PRESC1_OFF, 8'h00);
    partner.clr();
    pulse_count(3);
    tick(4);
    chk("undivided", partner.cap_cnt[1], 0);
    wr(`CH0_MODE_OFF, 8'h30);
    wr(`CH0_PIN_LOW_OFF, 8'h11);
    tick(2);
    chk("buffered oe", pin_oe_n[3:2], 2'b11);
    wr(`CH0_MODE_OFF, 8'h00);
    tick(2);
    chk("unbuffered oe", pin_oe_n[3:2], 2'b00);
    wr(`CH0_PIN_LOW_OFF, 8'h80);
    for (int i = 0; i < 2; i++)
    begin
      wr(`CH0_MODE_OFF, (i == 0) ? 8'h20 : 8'h00);
      partner.clr();
      partner.wiggle(3, 2);
      tick(4);
      chk("d capture", partner.cap_cnt[3], i);
    end
    wr(`CH1_MODE_OFF, 8'h05);
    wr(`CH0_PIN_HIGH_OFF, 8'hAB);
    hw_standby <= 1'b1;
    tick(6);
    hw_standby <= 1'b0;
    tick(4);
    mdl_reset();
    for (int i = 0; i < 9; i++)
      rd(8'(4 * i));
    conclude();
  end
endmodule
